// ==== logic/cpuex_regs.svh ====
// Purpose: constants of the cpu exception and edge logic
// Assumes: 32-bit classic wishbone, byte addresses below
// Notes:   the block keeps the status word and the exception save state
//----------------------------------------------------------------------
// What this block does
// - mask-all op sets the mask flag; unmask-all op clears it
// - handler return and status-word load also rewrite the mask flag
// - non-maskable requests and exceptions ignore the mask flag
// - accepting a maskable request sets the mask flag
// - maskable request waits while masked; taken when pending, unmasked and no op retires
// - software vector op raises a software exception unless its encoding is illegal
// - software exception saves pc and status, writes cause, sets flags
// - vector 00-0f goes to 00000040, vector 10-1f goes to 00000050
// - with fault flag set, handler return restores pc and status
// - fault flag is set on every exception
// - bits 10:5 all ones, 26:23 at least 0111, bit 16 zero is illegal
// - illegal op saves to debug registers, sets three flags, jumps 60
// - debug return restores pc and status from debug registers
// - debug save registers usable only between illegal op and return
// - debug break always taken, saves, sets flags, jumps 00000060
// - debug break ends with debug return; save registers gated alike
// - edge select pair: 00 none, 01 rising, 10 falling, 11 both
// - after reset the nonmask pin detects no edge
// - bit 2 nonmask pin, bits 3-6 ext pins 0-3, reset 00, byte access
// - a nonmask edge can wake from stop without the clock
// - reset loads the status word with 00000020
//----------------------------------------------------------------------
`ifndef CPUEX_REGS_SVH
`define CPUEX_REGS_SVH

// wishbone byte addresses
`define CPUEX_ADR_FALL   6'h00
`define CPUEX_ADR_RISE   6'h04
`define CPUEX_ADR_PSW    6'h08
`define CPUEX_ADR_TPC    6'h0c
`define CPUEX_ADR_TPSW   6'h10
`define CPUEX_ADR_CAUSE  6'h14
`define CPUEX_ADR_DPC    6'h18
`define CPUEX_ADR_DPSW   6'h1c

// system register numbers for the load op
`define CPUEX_SR_TPC     5'h00
`define CPUEX_SR_TPSW    5'h01
`define CPUEX_SR_CAUSE   5'h04
`define CPUEX_SR_PSW     5'h05
`define CPUEX_SR_DPC     5'h06
`define CPUEX_SR_DPSW    5'h07

// status word fields and reset
`define CPUEX_PSW_ID     5
`define CPUEX_PSW_EP     6
`define CPUEX_PSW_NP     7
`define CPUEX_PSW_RESET  32'h0000_0020

// edge register layout
`define CPUEX_EDGE_LSB   2
`define CPUEX_EDGE_RESET 8'h00

// handler addresses and cause code
`define CPUEX_VEC_LOW    32'h0000_0040
`define CPUEX_VEC_HIGH   32'h0000_0050
`define CPUEX_VEC_DEBUG  32'h0000_0060
`define CPUEX_CODE_BASE  16'h0040

`endif

// ==== logic/cpuex_pkg.sv ====
// Purpose: types of the cpu exception and edge logic
// Assumes: constants live in cpuex_regs.svh
// Notes:   the op code is one-hot, yet decode compares the whole 8-bit value
package cpuex_pkg;

    typedef enum logic [7:0] {
        OP_NONE     = 8'h01,
        OP_MASK     = 8'h02,
        OP_UNMASK   = 8'h04,
        OP_RETURN   = 8'h08,
        OP_SRLOAD   = 8'h10,
        OP_SWVEC    = 8'h20,
        OP_DBREAK   = 8'h40,
        OP_DBRETURN = 8'h80
    } cpuex_op_t;

    // one retiring instruction from the pipeline
    typedef struct packed {
        logic        valid;
        cpuex_op_t   op;
        logic [31:0] instr;
        logic [31:0] retPc;
        logic [4:0]  vector;
        logic [4:0]  srSel;
        logic [31:0] srData;
    } cpuex_cmd_t;

    // redirect handed back to the fetch stage
    typedef struct packed {
        logic        load;
        logic [31:0] target;
    } cpuex_jump_t;

    // whole register state of the block
    typedef struct packed {
        logic [31:0] program_status_word;
        logic [31:0] tpc;
        logic [31:0] tpsw;
        logic [31:0] cause;
        logic [31:0] dpc;
        logic [31:0] dpsw;
        logic        dbgWin;
        logic [7:0]  fallSel;
        logic [7:0]  riseSel;
        logic [4:0]  pinMeta;
        logic [4:0]  pinSync;
        logic [4:0]  pinLast;
        logic [4:0]  reqPulse;
        logic        maskAck;
        cpuex_jump_t jump;
        logic        ack;
        logic [31:0] rdData;
    } cpuex_state_t;

endpackage : cpuex_pkg

// ==== logic/cpuex_top.sv ====
// Purpose: exception entry and return, status word, request edge select
// Assumes: one retiring instruction a cycle at most, pins sync to sys_clk
// Notes:   redirect and new status word appear on the same edge
`timescale 1ns/1ps
`include "cpuex_regs.svh"

module cpuex_top
    import cpuex_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // pipeline side
    input  wire cpuex_cmd_t  cmd,
    output cpuex_jump_t      jump,
    output logic      [31:0] programStatusWord,
    output logic             debugWindow,
    // maskable request from the interrupt controller
    input  wire logic        requestPendingFlag,
    output logic             maskAccept,
    // request pins
    input  wire logic        nonmaskRequestPin,
    input  wire logic [3:0]  extRequestPin,
    output logic             nonmaskRequest,
    output logic      [3:0]  extRequest,
    output logic             stopWake
);

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    cpuex_state_t s_q;
    cpuex_state_t s_d;

    logic [4:0]  pinRaw;
    logic [4:0]  fallBits;
    logic [4:0]  riseBits;
    logic [4:0]  edgeHit;
    logic        illegalOp;
    logic        busReq;
    logic        busWr;
    logic        doExc;
    logic [31:0] swVecAddr;

    assign pinRaw   = {extRequestPin, nonmaskRequestPin};
    assign fallBits = s_q.fallSel[`CPUEX_EDGE_LSB +: 5];
    assign riseBits = s_q.riseSel[`CPUEX_EDGE_LSB +: 5];

    //------------------------------------------------------------------
    // edge detection, one lane per request pin
    //------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_edge
            // pair 00 yields nothing, so reset state sees no edge
            assign edgeHit[gi] =
                (riseBits[gi] & s_q.pinSync[gi] & ~s_q.pinLast[gi]) |
                (fallBits[gi] & ~s_q.pinSync[gi] & s_q.pinLast[gi]);
        end
    endgenerate

    // stop wake is combinational so it works while the clock is halted;
    // it compares the raw pin with the last level seen before stopping
    assign stopWake =
        (riseBits[0] & nonmaskRequestPin & ~s_q.pinLast[0]) |
        (fallBits[0] & ~nonmaskRequestPin & s_q.pinLast[0]);

    //------------------------------------------------------------------
    // instruction decode
    //------------------------------------------------------------------
    assign illegalOp = cmd.valid &&
                       (cmd.instr[10:5] == 6'h3f) &&
                       (cmd.instr[26:23] >= 4'h7) &&
                       !cmd.instr[16];

    // vector bit 4 picks the handler slot
    assign swVecAddr = cmd.vector[4] ? `CPUEX_VEC_HIGH
                                     : `CPUEX_VEC_LOW;

    assign doExc = illegalOp ||
                   (cmd.valid && (cmd.op == OP_SWVEC ||
                                  cmd.op == OP_DBREAK));

    assign busReq = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign busWr  = busReq && wb_we_i && wb_sel_i[0];

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.jump.load = 1'b0;
        s_d.maskAck   = 1'b0;
        s_d.ack       = 1'b0;

        // two-flop sync, then edge history
        s_d.pinMeta  = pinRaw;
        s_d.pinSync  = s_q.pinMeta;
        s_d.pinLast  = s_q.pinSync;
        s_d.reqPulse = edgeHit;

        // pipeline ops; an illegal opcode wins over whatever op it carries
        if (illegalOp)
        begin
            s_d.dpc  = cmd.retPc;
            s_d.dpsw = s_q.program_status_word;
            s_d.program_status_word[`CPUEX_PSW_NP] = 1'b1;
            s_d.program_status_word[`CPUEX_PSW_EP] = 1'b1;
            s_d.program_status_word[`CPUEX_PSW_ID] = 1'b1;
            s_d.dbgWin      = 1'b1;
            s_d.jump.load   = 1'b1;
            s_d.jump.target = `CPUEX_VEC_DEBUG;
        end
        else if (cmd.valid)
        begin
            case (cmd.op)
                OP_MASK:
                begin
                    s_d.program_status_word[`CPUEX_PSW_ID] = 1'b1;
                end
                OP_UNMASK:
                begin
                    s_d.program_status_word[`CPUEX_PSW_ID] = 1'b0;
                end
                OP_SWVEC:
                begin
                    // never gated by any mask flag
                    s_d.tpc   = cmd.retPc;
                    s_d.tpsw  = s_q.program_status_word;
                    s_d.cause[15:0] = `CPUEX_CODE_BASE +
                                      {11'h000, cmd.vector};
                    s_d.program_status_word[`CPUEX_PSW_EP] = 1'b1;
                    s_d.program_status_word[`CPUEX_PSW_ID] = 1'b1;
                    s_d.jump.load   = 1'b1;
                    s_d.jump.target = swVecAddr;
                end
                OP_DBREAK:
                begin
                    s_d.dpc  = cmd.retPc;
                    s_d.dpsw = s_q.program_status_word;
                    s_d.program_status_word[`CPUEX_PSW_NP] = 1'b1;
                    s_d.program_status_word[`CPUEX_PSW_EP] = 1'b1;
                    s_d.program_status_word[`CPUEX_PSW_ID] = 1'b1;
                    s_d.dbgWin      = 1'b1;
                    s_d.jump.load   = 1'b1;
                    s_d.jump.target = `CPUEX_VEC_DEBUG;
                end
                OP_RETURN:
                begin
                    // only the fault path has save registers here;
                    // with the fault flag clear the return is ignored
                    if (s_q.program_status_word[`CPUEX_PSW_EP])
                    begin
                        s_d.program_status_word         = s_q.tpsw;
                        s_d.jump.load   = 1'b1;
                        s_d.jump.target = s_q.tpc;
                    end
                end
                OP_DBRETURN:
                begin
                    s_d.program_status_word         = s_q.dpsw;
                    s_d.dbgWin      = 1'b0;
                    s_d.jump.load   = 1'b1;
                    s_d.jump.target = s_q.dpc;
                end
                OP_SRLOAD:
                begin
                    case (cmd.srSel)
                        `CPUEX_SR_PSW:   s_d.program_status_word   = cmd.srData;
                        `CPUEX_SR_TPC:   s_d.tpc   = cmd.srData;
                        `CPUEX_SR_TPSW:  s_d.tpsw  = cmd.srData;
                        `CPUEX_SR_CAUSE: s_d.cause = cmd.srData;
                        `CPUEX_SR_DPC:
                        begin
                            if (s_q.dbgWin)
                                s_d.dpc = cmd.srData;
                        end
                        `CPUEX_SR_DPSW:
                        begin
                            if (s_q.dbgWin)
                                s_d.dpsw = cmd.srData;
                        end
                        default: s_d.cause = s_q.cause;
                    endcase
                end
                default:
                begin
                    s_d.jump.load = 1'b0;
                end
            endcase
        end

        // maskable request: lower priority than any op this cycle,
        // and any op that retires, status-word op or not, holds it off that cycle
        if (requestPendingFlag && !s_q.program_status_word[`CPUEX_PSW_ID] &&
            !doExc && !cmd.valid && !s_q.maskAck)
        begin
            s_d.maskAck = 1'b1;
            s_d.program_status_word[`CPUEX_PSW_ID] = 1'b1;
        end

        // wishbone: one wait state, ack stands one cycle
        if (busReq)
        begin
            s_d.ack = 1'b1;
            case (wb_adr_i)
                `CPUEX_ADR_FALL:  s_d.rdData = {24'h000000, s_q.fallSel};
                `CPUEX_ADR_RISE:  s_d.rdData = {24'h000000, s_q.riseSel};
                `CPUEX_ADR_PSW:   s_d.rdData = s_q.program_status_word;
                `CPUEX_ADR_TPC:   s_d.rdData = s_q.tpc;
                `CPUEX_ADR_TPSW:  s_d.rdData = s_q.tpsw;
                `CPUEX_ADR_CAUSE: s_d.rdData = s_q.cause;
                `CPUEX_ADR_DPC:
                    s_d.rdData = s_q.dbgWin ? s_q.dpc : 32'h0;
                `CPUEX_ADR_DPSW:
                    s_d.rdData = s_q.dbgWin ? s_q.dpsw : 32'h0;
                default:          s_d.rdData = 32'h0;
            endcase
            // byte lane 0 only; upper lanes are ignored
            if (busWr && wb_adr_i == `CPUEX_ADR_FALL)
                s_d.fallSel = wb_dat_i[7:0];
            if (busWr && wb_adr_i == `CPUEX_ADR_RISE)
                s_d.riseSel = wb_dat_i[7:0];
        end
    end

    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q          <= '0;
            s_q.program_status_word      <= `CPUEX_PSW_RESET;
            s_q.fallSel  <= `CPUEX_EDGE_RESET;
            s_q.riseSel  <= `CPUEX_EDGE_RESET;
        end
        else
        begin
            s_q <= s_d; // saves and flags land with the redirect
        end
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    assign jump              = s_q.jump;
    assign programStatusWord = s_q.program_status_word;
    assign debugWindow       = s_q.dbgWin;
    assign maskAccept        = s_q.maskAck;
    assign nonmaskRequest    = s_q.reqPulse[0];
    assign extRequest        = s_q.reqPulse[4:1];
    assign wb_ack_o          = s_q.ack;
    assign wb_dat_o          = s_q.rdData;

endmodule : cpuex_top

// ==== verif/cpuex_top_checker.sv ====
// Purpose: concurrent checks on the ports of the exception block
// Assumes: single clock domain, reset active low
// Notes:   illegal decode outranks the op, so ops count only when legal
`timescale 1ns/1ps
`include "cpuex_regs.svh"
module cpuex_top_checker
    import cpuex_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // pipeline side
    input wire cpuex_cmd_t  cmd,
    input wire cpuex_jump_t jump,
    input wire logic [31:0] programStatusWord,
    input wire logic        debugWindow,
    // requests
    input wire logic        requestPendingFlag,
    input wire logic        maskAccept,
    input wire logic        nonmaskRequestPin,
    input wire logic        nonmaskRequest
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic       ill;
    logic       go;
    logic       idFlag;
    logic       epFlag;
    logic [4:0] vec;
    // decode shadow, kept apart from the op so priority is explicit
    assign ill = cmd.valid && cmd.instr[10:5] == 6'h3f
               && cmd.instr[26:23] >= 4'h7 && !cmd.instr[16];
    assign go = cmd.valid && !ill;
    assign idFlag = programStatusWord[`CPUEX_PSW_ID];
    assign epFlag = programStatusWord[`CPUEX_PSW_EP];
    assign vec = cmd.vector;
    mask_set_a: assert property (go && cmd.op == OP_MASK |=> idFlag)
        else $error("mask op left the mask flag clear");
    unmask_clr_a: assert property (go && cmd.op == OP_UNMASK |=> !idFlag)
        else $error("unmask op left the mask flag set");
    accept_id_a: assert property (maskAccept |-> idFlag && !$past(idFlag))
        else $error("accept without mask flag change");
    accept_due_a: assert property (requestPendingFlag && !idFlag
        && !cmd.valid && !maskAccept |=> maskAccept)
        else $error("pending request not accepted");
    swvec_entry_a: assert property (go && cmd.op == OP_SWVEC |=> jump.load
        && jump.target == ($past(vec) < 5'h10 ? 32'h40 : 32'h50)
        && programStatusWord[6:5] == 2'h3) else $error("bad trap entry");
    dbg_entry_a: assert property (ill || go && cmd.op == OP_DBREAK
        |=> jump.load && jump.target == 32'h60 && debugWindow
        && programStatusWord[7:5] == 3'h7) else $error("bad debug entry");
    dbg_return_a: assert property (go && cmd.op == OP_DBRETURN
        |=> jump.load && !debugWindow) else $error("bad debug return");
    ret_gate_a: assert property (go && cmd.op == OP_RETURN
        |=> jump.load == $past(epFlag)) else $error("return gate wrong");
    edge_pulse_a: assert property (nonmaskRequest |->
        $past(nonmaskRequestPin, 3) != $past(nonmaskRequestPin, 4))
        else $error("request pulse without pin edge");
    cover property (go && cmd.op == OP_SWVEC);
    cover property (maskAccept);
    cover property (nonmaskRequest);
endmodule : cpuex_top_checker
bind cpuex_top cpuex_top_checker cpuex_top_checker_i (.sys_clk(sys_clk),
    .rst_b(rst_b), .cmd(cmd), .jump(jump), .debugWindow(debugWindow),
    .programStatusWord(programStatusWord), .maskAccept(maskAccept),
    .requestPendingFlag(requestPendingFlag), .nonmaskRequest(nonmaskRequest),
    .nonmaskRequestPin(nonmaskRequestPin));

// ==== verif/cpuex_pipe_model.sv ====
// Purpose: pipeline, interrupt controller and pin side of the block
// Assumes: called from the bench through its tasks
// Notes:   pending flag holds until accepted, as a real controller does
`timescale 1ns/1ps
module cpuex_pipe_model
    import cpuex_pkg::*;
(
    // clock and answers
    input  wire logic        sys_clk,
    input  wire logic        maskAccept,
    input  wire cpuex_jump_t jump,
    // driven side
    output cpuex_cmd_t       cmd,
    output logic             requestPendingFlag,
    output logic             nonmaskRequestPin,
    output logic [3:0]       extRequestPin
);
    initial
    begin
        cmd = '0;
        cmd.op = OP_NONE;
        requestPendingFlag = 1'h0;
        nonmaskRequestPin = 1'h0;
        extRequestPin = 4'h0;
    end
    // controller drops its flag only once the cpu took it
    always @(posedge sys_clk)
        if (maskAccept)
            requestPendingFlag <= 1'h0;
    task automatic exec(input cpuex_op_t o, input logic [31:0] i, p,
        input logic [4:0] s, input logic [31:0] d, output cpuex_jump_t j);
        @(posedge sys_clk);
        cmd <= '{1'h1, o, i, p, s, s, d};
        @(posedge sys_clk);
        cmd.valid <= 1'h0;
        #1 j = jump;
    endtask : exec
    task automatic pend;
        @(posedge sys_clk);
        requestPendingFlag <= 1'h1;
    endtask : pend
    // pins change only on the clock, each level held many cycles
    task automatic pins(input logic n, input logic [3:0] e);
        @(posedge sys_clk);
        nonmaskRequestPin <= n;
        extRequestPin <= e;
    endtask : pins
endmodule : cpuex_pipe_model

// ==== verif/testbench.sv ====
// Purpose: self-checking bench of the exception and edge block
// Assumes: wishbone master and pipeline model driven at rising edges
// Notes:   pulse counters run in the background of every scenario
`timescale 1ns/1ps
`include "cpuex_regs.svh"
module testbench
    import cpuex_pkg::*;
;
    logic        sys_clk, rst_b, wbCyc, wbStb, wbWe, wbAck, debugWindow;
    logic        requestPendingFlag, maskAccept, nmPin, nmReq;
    logic [5:0]  wbAdr;
    logic [31:0] wbDatW, wbDatR, rd, program_status_word;
    logic [3:0]  exPin, exReq, wbSel;
    logic        wake;
    cpuex_cmd_t  cmd;
    cpuex_jump_t jump, j;
    int          errCount, checked, cycles, accCnt, nmCnt, exCnt;
    cpuex_top cpuex_top_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .cmd(cmd), .jump(jump), .programStatusWord(program_status_word),
        .debugWindow(debugWindow), .requestPendingFlag(requestPendingFlag),
        .maskAccept(maskAccept), .nonmaskRequestPin(nmPin),
        .extRequestPin(exPin), .nonmaskRequest(nmReq), .extRequest(exReq),
        .stopWake(wake));
    cpuex_pipe_model cpuex_pipe_model_i (.sys_clk(sys_clk), .cmd(cmd),
        .maskAccept(maskAccept), .jump(jump), .nonmaskRequestPin(nmPin),
        .requestPendingFlag(requestPendingFlag), .extRequestPin(exPin));
    always #5 sys_clk = ~sys_clk;
    // background counters; the ceiling cuts a hang short
    always @(posedge sys_clk)
    begin
        cycles++;
        accCnt += int'(maskAccept);
        nmCnt += int'(nmReq);
        exCnt += $countones(exReq);
        if (cycles == 5000)
        begin
            errCount++;
            endSim;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [5:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'h3, w, a, d};
        do @(posedge sys_clk); while (wbAck !== 1'h1);
        q = wbDatR;
        {wbCyc, wbStb} <= 2'h0;
    endtask : wb
    task automatic ex(input cpuex_op_t o, input logic [31:0] i, p,
        input logic [4:0] s, input logic [31:0] d);
        cpuex_pipe_model_i.exec(o, i, p, s, d, j);
    endtask : ex
    task automatic tRegs;
        wb(1'h0, `CPUEX_ADR_RISE, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'h0, `CPUEX_ADR_PSW, 32'h0, rd);
        chk(rd, 32'h20);
        wb(1'h1, `CPUEX_ADR_FALL, 32'hff, rd);
        wb(1'h0, `CPUEX_ADR_FALL, 32'h0, rd);
        chk(rd, 32'hff);
        // lane 0 off: the write must leave the byte alone
        wbSel <= 4'he;
        wb(1'h1, `CPUEX_ADR_FALL, 32'h0, rd);
        wbSel <= 4'hf;
        wb(1'h0, `CPUEX_ADR_FALL, 32'h0, rd);
        chk(rd, 32'hff);
        wb(1'h0, 6'h3c, 32'h0, rd);
        chk(rd, 32'h0);
        ex(OP_UNMASK, 32'h0, 32'h0, 5'h0, 32'h0);
        chk(program_status_word, 32'h0);
        ex(OP_MASK, 32'h0, 32'h0, 5'h0, 32'h0);
        chk(program_status_word, 32'h20);
    endtask : tRegs
    task automatic tAccept;
        int a;
        a = accCnt;
        cpuex_pipe_model_i.pend;
        repeat (5) @(posedge sys_clk);
        chk(32'(accCnt - a), 32'h0);
        ex(OP_UNMASK, 32'h0, 32'h0, 5'h0, 32'h0);
        repeat (3) @(posedge sys_clk);
        #1 chk(32'(accCnt - a), 32'h1);
        chk(program_status_word, 32'h20);
    endtask : tAccept
    // vectors on both sides of the 0f/10 boundary, taken while masked
    task automatic tSwvec;
        logic [4:0]  v;
        logic [31:0] p;
        for (int k = 0; k < 2; k++)
        begin
            v = k ? 5'h10 : 5'h0f;
            p = 32'h1000 + 32'(k);
            ex(OP_SWVEC, 32'h0, p, v, 32'h0);
            chk(j.target, k ? 32'h50 : 32'h40);
            chk(program_status_word, 32'h60);
            wb(1'h0, `CPUEX_ADR_TPC, 32'h0, rd);
            chk(rd, p);
            wb(1'h0, `CPUEX_ADR_TPSW, 32'h0, rd);
            chk(rd, 32'h20);
            wb(1'h0, `CPUEX_ADR_CAUSE, 32'h0, rd);
            chk(32'(rd[15:0]), 32'h40 + 32'(v));
            ex(OP_SRLOAD, 32'h0, 32'h0, `CPUEX_SR_PSW, 32'h40);
            chk(program_status_word, 32'h40);
            ex(OP_RETURN, 32'h0, 32'h0, 5'h0, 32'h0);
            chk(j.target, p);
            chk(program_status_word, 32'h20);
            ex(OP_RETURN, 32'h0, 32'h0, 5'h0, 32'h0);
            chk(32'(j.load), 32'h0);
        end
    endtask : tSwvec
    // near-miss encodings first, then the illegal op and the debug break
    task automatic tDebug;
        logic [31:0] p;
        ex(OP_NONE, 32'h0300_07e0, 32'h0, 5'h0, 32'h0);
        chk(32'(j.load), 32'h0);
        ex(OP_NONE, 32'h0781_07e0, 32'h0, 5'h0, 32'h0);
        chk(32'(j.load), 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            p = 32'h2000 + 32'(k);
            ex(k ? OP_DBREAK : OP_NONE, k ? 32'h0 : 32'h0380_07e0, p, 5'h0,
                32'h0);
            chk(j.target, 32'h60);
            chk(program_status_word, 32'he0);
            wb(1'h0, `CPUEX_ADR_DPC, 32'h0, rd);
            chk(rd, p);
            wb(1'h0, `CPUEX_ADR_DPSW, 32'h0, rd);
            chk(rd, 32'h20);
            ex(OP_DBRETURN, 32'h0, 32'h0, 5'h0, 32'h0);
            chk(j.target, p);
            chk({program_status_word[30:0], debugWindow}, 32'h40);
            wb(1'h0, `CPUEX_ADR_DPC, 32'h0, rd);
            chk(rd, 32'h0);
        end
    endtask : tDebug
    // pairs 00, 01, 10, 11, and back to 00 before the pins are idle
    task automatic tEdge;
        int n;
        int e;
        for (int k = 0; k < 5; k++)
        begin
            wb(1'h1, `CPUEX_ADR_FALL, {25'h0, {5{k[1]}}, 2'h0}, rd);
            wb(1'h1, `CPUEX_ADR_RISE, {25'h0, {5{k[0]}}, 2'h0}, rd);
            n = nmCnt;
            e = exCnt;
            cpuex_pipe_model_i.pins(1'h1, 4'hf);
            #1 chk(32'(wake), 32'(k[0]));
            repeat (6) @(posedge sys_clk);
            chk(32'(wake), 32'h0);
            chk(32'(nmCnt - n), 32'(k[0]));
            chk(32'(exCnt - e), 32'(4 * k[0]));
            n = nmCnt;
            e = exCnt;
            cpuex_pipe_model_i.pins(1'h0, 4'h0);
            #1 chk(32'(wake), 32'(k[1]));
            repeat (6) @(posedge sys_clk);
            chk(32'(nmCnt - n), 32'(k[1]));
            chk(32'(exCnt - e), 32'(4 * k[1]));
        end
    endtask : tEdge
    task automatic endSim;
        $display("mismatches %0d comparisons %0d", errCount, checked);
        if (errCount == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : endSim
    initial
    begin
        sys_clk = 1'h0;
        rst_b = 1'h0;
        {wbCyc, wbStb, wbWe, wbAdr, wbDatW} = '0;
        wbSel = 4'hf;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'h1;
        tRegs;
        tAccept;
        tSwvec;
        tDebug;
        tEdge;
        endSim;
    end
endmodule : testbench
